// [src/rsu_core.sv]
// rotate/shift instruction unit: prefix decode, machine-cycle sequencing, APB registers
// Functional notes
// - register field 000..101 selects B,C,D,E,H,L; 111 selects A.
// - plain forms are CB then op; indexed forms are DD/FD, CB, displacement, op.
// - op byte 1E after CB is rotate right via carry on memory; low bits name register.
// - op byte 26 after CB is arithmetic left shift on memory; low bits name register.
// - circular right rotate; old bit 0 goes to carry and to bit 7.
// - right rotate via carry; old bit 0 to carry, old carry to bit 7.
// - arithmetic left shift moves bits up; old bit 7 goes to carry.
// - register form 8 states, pointer form 15, indexed forms 23.
// - sign is result bit 7, zero when result zero, half-carry and subtract cleared.
// - parity flag set when result has an even count of ones.
// - both right rotates leave old bit 0 in carry.
// - arithmetic left shift leaves old bit 7 in carry.
// - op byte 0E after CB, indexed too, is circular right rotate on memory.
`timescale 1ns/100ps
`include "rsu_defs.svh"
module rsu_core
    import rsu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] memAddr,
    output logic memRd,
    output logic memWr,
    output logic [7:0] memWdata,
    input wire logic [7:0] memRdata
);
    function automatic rsu_op_e decode_op(input logic [7:0] code);
        if (code[7:3] == `RSU_PAT_CIRC) begin
            decode_op = RSU_OP_CIRC;
        end else if (code[7:3] == `RSU_PAT_CARRY) begin
            decode_op = RSU_OP_CARRY;
        end else if (code[7:3] == `RSU_PAT_SHL) begin
            decode_op = RSU_OP_SHL;
        end else begin
            decode_op = RSU_OP_BAD;
        end
    endfunction

    rsu_state_e state;
    rsu_mcyc_e mKind;
    rsu_mcyc_e nextKind;
    logic [2:0] tCnt;
    logic [2:0] mLen;
    logic [2:0] nextLen;
    logic [15:0] pc;
    logic [15:0] indexX;
    logic [15:0] indexY;
    logic [7:0] regFile [0:7];
    logic [7:0] flags;
    logic [7:0] opByte;
    logic [7:0] dispByte;
    logic idxForm;
    logic idxUseY;
    logic [15:0] opAddr;
    logic [7:0] lastResult;
    logic [4:0] instStates;
    logic [4:0] lastStates;
    logic doneSticky;
    logic badSticky;
    logic endInst;
    logic failInst;
    logic [31:0] readMux;
    logic addrHit;

    // machine-cycle decode
    wire logic lastT = (state == ST_RUN) && (tCnt == mLen - 3'h1);
    wire logic [7:0] curOp = (mKind == MC_OP) ? memRdata : opByte;
    wire rsu_op_e opClass = decode_op(curOp);
    wire logic memForm = idxForm || (curOp[2:0] == `RSU_MEM_FIELD);
    wire logic opBad = (opClass == RSU_OP_BAD) || (idxForm && curOp[2:0] != `RSU_MEM_FIELD);
    wire logic [7:0] aluIn = (mKind == MC_READ) ? memRdata : regFile[curOp[2:0]];
    wire logic execNow = lastT && ((mKind == MC_OP && !opBad && !memForm) || mKind == MC_READ);
    wire logic [15:0] idxBase = idxUseY ? indexY : indexX;
    wire logic [15:0] effAddr = idxForm ? (idxBase + {{8{dispByte[7]}}, dispByte}) :
                                {regFile[`RSU_R_H], regFile[`RSU_R_L]};
    wire logic issueFetch = (nextKind == MC_CB) || (nextKind == MC_DISP) || (nextKind == MC_OP);
    wire logic [7:0] aluOut;
    wire logic [7:0] aluFlags;

    // apb decode
    wire logic apbSetup = psel && !penable;
    wire logic apbWrite = psel && penable && pready && pwrite && !pslverr;
    wire logic idle = (state == ST_IDLE);
    wire logic startReq = apbWrite && paddr == `RSU_ADDR_CTRL && pwdata[`RSU_CTRL_START] && idle;
    wire logic regWrite = apbWrite && idle;
    wire logic clrDone = apbWrite && paddr == `RSU_ADDR_STATUS && pwdata[`RSU_STAT_DONE];
    wire logic clrBad = apbWrite && paddr == `RSU_ADDR_STATUS && pwdata[`RSU_STAT_BAD];

    rsu_alu u_alu (
        .aluOp(opClass),
        .operand(aluIn),
        .carryIn(flags[`RSU_FLAG_C]),
        .result(aluOut),
        .flagsOut(aluFlags)
    );

    // next machine cycle after the current one completes
    always_comb begin
        nextKind = mKind;
        nextLen = mLen;
        endInst = 1'b0;
        failInst = 1'b0;
        case (mKind)
            MC_PREFIX: begin
                if (memRdata == `RSU_PFX_CB) begin
                    nextKind = MC_OP;
                    nextLen = `RSU_LEN_OP;
                end else if (memRdata == `RSU_PFX_IDXX || memRdata == `RSU_PFX_IDXY) begin
                    nextKind = MC_CB;
                    nextLen = `RSU_LEN_CB;
                end else begin
                    failInst = 1'b1;
                end
            end
            MC_CB: begin
                if (memRdata == `RSU_PFX_CB) begin
                    nextKind = MC_DISP;
                    nextLen = `RSU_LEN_DISP;
                end else begin
                    failInst = 1'b1;
                end
            end
            MC_DISP: begin
                nextKind = MC_OP;
                nextLen = `RSU_LEN_OPX;
            end
            MC_OP: begin
                if (opBad) begin
                    failInst = 1'b1;
                end else if (memForm) begin
                    nextKind = MC_READ;
                    nextLen = `RSU_LEN_READ;
                end else begin
                    endInst = 1'b1;
                end
            end
            MC_READ: begin
                nextKind = MC_WRITE;
                nextLen = `RSU_LEN_WRITE;
            end
            default: begin
                endInst = 1'b1;
            end
        endcase
    end

    // sequencer and memory strobes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            mKind <= MC_PREFIX;
            mLen <= `RSU_LEN_PREFIX;
            tCnt <= 3'h0;
            pc <= `RSU_RST_PC;
            memAddr <= 16'h0000;
            memRd <= 1'b0;
            memWr <= 1'b0;
            memWdata <= 8'h00;
            opByte <= 8'h00;
            dispByte <= 8'h00;
            idxForm <= 1'b0;
            idxUseY <= 1'b0;
            opAddr <= 16'h0000;
            instStates <= 5'h00;
            lastStates <= 5'h00;
        end else begin
            memRd <= 1'b0;
            memWr <= 1'b0;
            if (startReq) begin
                state <= ST_RUN;
                mKind <= MC_PREFIX;
                mLen <= `RSU_LEN_PREFIX;
                tCnt <= 3'h0;
                memRd <= 1'b1;
                memAddr <= pc;
                pc <= pc + 16'h0001;
                idxForm <= 1'b0;
                instStates <= 5'h00;
            end else if (regWrite && paddr == `RSU_ADDR_PC) begin
                pc <= pwdata[15:0];
            end else if (state == ST_RUN) begin
                instStates <= instStates + 5'h01;
                tCnt <= tCnt + 3'h1;
                if (lastT) begin
                    if (mKind == MC_PREFIX) begin
                        idxForm <= (memRdata != `RSU_PFX_CB);
                        idxUseY <= (memRdata == `RSU_PFX_IDXY);
                    end
                    if (mKind == MC_DISP) begin
                        dispByte <= memRdata;
                    end
                    if (mKind == MC_OP) begin
                        opByte <= memRdata;
                        opAddr <= effAddr;
                    end
                    if (endInst || failInst) begin
                        state <= ST_IDLE;
                        if (endInst) begin
                            lastStates <= instStates + 5'h01;
                        end
                    end else begin
                        mKind <= nextKind;
                        mLen <= nextLen;
                        tCnt <= 3'h0;
                        if (issueFetch) begin
                            memRd <= 1'b1;
                            memAddr <= pc;
                            pc <= pc + 16'h0001;
                        end else if (nextKind == MC_READ) begin
                            memRd <= 1'b1;
                            memAddr <= effAddr;
                        end else begin
                            memWr <= 1'b1;
                            memAddr <= opAddr;
                            memWdata <= aluOut;
                        end
                    end
                end
            end
        end
    end

    // operand registers, flags and status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                regFile[i] <= `RSU_RST_REG;
            end
            flags <= `RSU_RST_REG;
            indexX <= 16'h0000;
            indexY <= 16'h0000;
            lastResult <= 8'h00;
            doneSticky <= 1'b0;
            badSticky <= 1'b0;
        end else begin
            doneSticky <= (lastT && endInst) || (doneSticky && !clrDone);
            badSticky <= (lastT && failInst) || (badSticky && !clrBad);
            if (execNow) begin
                flags <= aluFlags;
                lastResult <= aluOut;
                if (mKind == MC_OP) begin
                    regFile[curOp[2:0]] <= aluOut;
                end
            end else if (regWrite) begin
                if (paddr == `RSU_ADDR_FLAGS) begin
                    flags <= pwdata[7:0];
                end else if (paddr == `RSU_ADDR_BC) begin
                    regFile[`RSU_R_B] <= pwdata[15:8];
                    regFile[`RSU_R_C] <= pwdata[7:0];
                end else if (paddr == `RSU_ADDR_DE) begin
                    regFile[`RSU_R_D] <= pwdata[15:8];
                    regFile[`RSU_R_E] <= pwdata[7:0];
                end else if (paddr == `RSU_ADDR_PTR) begin
                    regFile[`RSU_R_H] <= pwdata[15:8];
                    regFile[`RSU_R_L] <= pwdata[7:0];
                end else if (paddr == `RSU_ADDR_A) begin
                    regFile[`RSU_R_A] <= pwdata[7:0];
                end else if (paddr == `RSU_ADDR_IDXX) begin
                    indexX <= pwdata[15:0];
                end else if (paddr == `RSU_ADDR_IDXY) begin
                    indexY <= pwdata[15:0];
                end
            end
        end
    end

    // register read selection
    always_comb begin
        readMux = 32'h00000000;
        addrHit = 1'b1;
        if (paddr == `RSU_ADDR_CTRL) begin
            readMux = 32'h00000000;
        end else if (paddr == `RSU_ADDR_STATUS) begin
            readMux = {29'h00000000, badSticky, doneSticky, !idle};
        end else if (paddr == `RSU_ADDR_PC) begin
            readMux = {16'h0000, pc};
        end else if (paddr == `RSU_ADDR_FLAGS) begin
            readMux = {24'h000000, flags};
        end else if (paddr == `RSU_ADDR_BC) begin
            readMux = {16'h0000, regFile[`RSU_R_B], regFile[`RSU_R_C]};
        end else if (paddr == `RSU_ADDR_DE) begin
            readMux = {16'h0000, regFile[`RSU_R_D], regFile[`RSU_R_E]};
        end else if (paddr == `RSU_ADDR_PTR) begin
            readMux = {16'h0000, regFile[`RSU_R_H], regFile[`RSU_R_L]};
        end else if (paddr == `RSU_ADDR_A) begin
            readMux = {24'h000000, regFile[`RSU_R_A]};
        end else if (paddr == `RSU_ADDR_IDXX) begin
            readMux = {16'h0000, indexX};
        end else if (paddr == `RSU_ADDR_IDXY) begin
            readMux = {16'h0000, indexY};
        end else if (paddr == `RSU_ADDR_STATES) begin
            readMux = {27'h0000000, lastStates};
        end else begin
            addrHit = 1'b0;
        end
    end

    // apb answer: one access cycle, data captured at setup
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && !addrHit;
            prdata <= (apbSetup && !pwrite) ? readMux : 32'h00000000;
        end
    end

    // checks
    sequence s_exec(logic [4:0] pat);
        execNow && curOp[7:3] == pat;
    endsequence

    sequence s_writeback;
        memWr && memAddr == opAddr && memWdata == lastResult;
    endsequence

    property p_circ;
        @(posedge core_clk) disable iff (!rst_n)
        s_exec(`RSU_PAT_CIRC) |=> lastResult == {$past(aluIn[0]), $past(aluIn[7:1])}
            && flags[0] == $past(aluIn[0]);
    endproperty
    a_circ: assert property (p_circ) else $error("circular rotate wrong");

    property p_carry_rot;
        @(posedge core_clk) disable iff (!rst_n)
        s_exec(`RSU_PAT_CARRY) |=> lastResult == {$past(flags[0]), $past(aluIn[7:1])};
    endproperty
    a_carry_rot: assert property (p_carry_rot) else $error("rotate via carry wrong");

    property p_shl;
        @(posedge core_clk) disable iff (!rst_n)
        s_exec(`RSU_PAT_SHL) |=> lastResult == {$past(aluIn[6:0]), 1'b0};
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");

    property p_carry_right;
        @(posedge core_clk) disable iff (!rst_n)
        execNow && opClass != RSU_OP_SHL |=> flags[`RSU_FLAG_C] == $past(aluIn[0]);
    endproperty
    a_carry_right: assert property (p_carry_right) else $error("right rotate carry wrong");

    property p_carry_left;
        @(posedge core_clk) disable iff (!rst_n)
        s_exec(`RSU_PAT_SHL) |=> flags[`RSU_FLAG_C] == $past(aluIn[7]) && lastResult[0] == 1'b0;
    endproperty
    a_carry_left: assert property (p_carry_left) else $error("left shift carry wrong");

    property p_sz;
        @(posedge core_clk) disable iff (!rst_n)
        execNow |=> flags[7] == lastResult[7] && flags[6] == (lastResult == 8'h00) && !flags[4] && !flags[1];
    endproperty
    a_sz: assert property (p_sz) else $error("sign zero flags wrong");

    property p_parity;
        @(posedge core_clk) disable iff (!rst_n)
        execNow |=> flags[`RSU_FLAG_PV] == ~^lastResult;
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");

    property p_regsel;
        @(posedge core_clk) disable iff (!rst_n)
        execNow && mKind == MC_OP |=> regFile[$past(curOp[2:0])] == lastResult;
    endproperty
    a_regsel: assert property (p_regsel) else $error("result not in selected register");

    property p_prefix;
        @(posedge core_clk) disable iff (!rst_n)
        lastT && mKind == MC_PREFIX && memRdata == `RSU_PFX_IDXX |=> mKind == MC_CB && memRd ##3 lastT
            ##1 (mKind == MC_DISP && memRd || state == ST_IDLE && badSticky);
    endproperty
    a_prefix: assert property (p_prefix) else $error("indexed prefix order wrong");

    property p_length;
        @(posedge core_clk) disable iff (!rst_n)
        lastT && endInst |-> instStates + 5'h01 == (idxForm ? `RSU_STATES_IDX :
                                 memForm ? `RSU_STATES_PTR : `RSU_STATES_REG);
    endproperty
    a_length: assert property (p_length) else $error("instruction length wrong");

    property p_rmw;
        @(posedge core_clk) disable iff (!rst_n)
        lastT && mKind == MC_READ |=> s_writeback ##2 lastT && endInst;
    endproperty
    a_rmw: assert property (p_rmw) else $error("write back wrong");
endmodule

// [shared/rsu_defs.svh]
// offsets, field positions, codes, reset values and cycle counts of the rotate/shift unit
`ifndef RSU_DEFS_SVH
`define RSU_DEFS_SVH

`define RSU_ADDR_CTRL 8'h00
`define RSU_ADDR_STATUS 8'h04
`define RSU_ADDR_PC 8'h08
`define RSU_ADDR_FLAGS 8'h0C
`define RSU_ADDR_BC 8'h10
`define RSU_ADDR_DE 8'h14
`define RSU_ADDR_PTR 8'h18
`define RSU_ADDR_A 8'h1C
`define RSU_ADDR_IDXX 8'h20
`define RSU_ADDR_IDXY 8'h24
`define RSU_ADDR_STATES 8'h28

`define RSU_CTRL_START 0
`define RSU_STAT_BUSY 0
`define RSU_STAT_DONE 1
`define RSU_STAT_BAD 2

`define RSU_FLAG_S 7
`define RSU_FLAG_Z 6
`define RSU_FLAG_H 4
`define RSU_FLAG_PV 2
`define RSU_FLAG_N 1
`define RSU_FLAG_C 0

`define RSU_R_B 3'h0
`define RSU_R_C 3'h1
`define RSU_R_D 3'h2
`define RSU_R_E 3'h3
`define RSU_R_H 3'h4
`define RSU_R_L 3'h5
`define RSU_R_A 3'h7
`define RSU_MEM_FIELD 3'h6

`define RSU_PFX_CB 8'hCB
`define RSU_PFX_IDXX 8'hDD
`define RSU_PFX_IDXY 8'hFD
`define RSU_PAT_CIRC 5'h01
`define RSU_PAT_CARRY 5'h03
`define RSU_PAT_SHL 5'h04

`define RSU_LEN_PREFIX 3'h4
`define RSU_LEN_CB 3'h4
`define RSU_LEN_DISP 3'h3
`define RSU_LEN_OP 3'h4
`define RSU_LEN_OPX 3'h5
`define RSU_LEN_READ 3'h4
`define RSU_LEN_WRITE 3'h3

`define RSU_STATES_REG 5'h08
`define RSU_STATES_PTR 5'h0F
`define RSU_STATES_IDX 5'h17

`define RSU_RST_REG 8'h00
`define RSU_RST_PC 16'h0000

`endif

// [shared/rsu_pkg.sv]
// types shared by the rotate/shift unit
package rsu_pkg;
    typedef enum logic [1:0] {RSU_OP_CIRC, RSU_OP_CARRY, RSU_OP_SHL, RSU_OP_BAD} rsu_op_e;
    typedef enum logic [2:0] {MC_PREFIX, MC_CB, MC_DISP, MC_OP, MC_READ, MC_WRITE} rsu_mcyc_e;
    typedef enum logic {ST_IDLE, ST_RUN} rsu_state_e;
endpackage

// [src/rsu_alu.sv]
// bit movement and flag generation for the rotate/shift unit
`timescale 1ns/100ps
`include "rsu_defs.svh"
module rsu_alu
    import rsu_pkg::*;
(
    input rsu_op_e aluOp,
    input wire logic [7:0] operand,
    input wire logic carryIn,
    output logic [7:0] result,
    output logic [7:0] flagsOut
);
    logic carryOut;

    assign result = (aluOp == RSU_OP_CIRC) ? {operand[0], operand[7:1]} :
                    (aluOp == RSU_OP_CARRY) ? {carryIn, operand[7:1]} :
                    {operand[6:0], 1'b0};
    assign carryOut = (aluOp == RSU_OP_SHL) ? operand[7] : operand[0];

    always_comb begin
        flagsOut = 8'h00;
        flagsOut[`RSU_FLAG_S] = result[7];
        flagsOut[`RSU_FLAG_Z] = (result == 8'h00);
        flagsOut[`RSU_FLAG_PV] = ~^result;
        flagsOut[`RSU_FLAG_C] = carryOut;
    end
endmodule

// [testbench/rsu_mem_model.sv]
// behavioural byte memory serving fetch, operand read and write-back cycles
`timescale 1ns/100ps
module rsu_mem_model (
    input wire logic core_clk,
    input wire logic [15:0] memAddr,
    input wire logic memRd,
    input wire logic memWr,
    input wire logic [7:0] memWdata,
    input wire logic slow,
    output logic [7:0] memRdata
);
    logic [7:0] mem [0:65535];
    logic [15:0] rdAddr = 16'h0000;
    logic pending = 1'b0;
    initial memRdata = 8'h00;
    // slow answers one clock late; until then the bus shows a changing pattern
    always @(posedge core_clk) begin
        if (memWr === 1'b1) begin
            mem[memAddr] <= memWdata;
        end
        if (memRd === 1'b1) begin
            rdAddr <= memAddr;
            pending <= slow;
            memRdata <= slow ? ~memRdata : mem[memAddr];
        end else if (pending) begin
            memRdata <= mem[rdAddr];
            pending <= 1'b0;
        end
    end
endmodule

// [testbench/rsu_core_tb.sv]
// self-checking bench for the rotate/shift unit with a behavioural memory
`timescale 1ns/100ps
`include "rsu_defs.svh"
module rsu_core_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] memAddr;
    logic memRd;
    logic memWr;
    logic [7:0] memWdata;
    logic [7:0] memRdata;
    logic slow = 1'b0;
    int numErrors = 0;
    int nTests = 0;
    int rdCnt = 0;
    int wrCnt = 0;

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (memRd === 1'b1) rdCnt++;
        if (memWr === 1'b1) wrCnt++;
    end

    rsu_core rsu_core_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memAddr(memAddr),
        .memRd(memRd), .memWr(memWr), .memWdata(memWdata), .memRdata(memRdata));
    rsu_mem_model rsu_mem_model_i (.core_clk(core_clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
        .memWdata(memWdata), .slow(slow), .memRdata(memRdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic wrapUp();
        $display("checks=%0d errors=%0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // returns {carry, result}
    function automatic logic [8:0] ref_op(input logic [1:0] k, input logic [7:0] v, input logic c);
        case (k)
            2'h0: return {v[0], v[0], v[7:1]};
            2'h1: return {v[0], c, v[7:1]};
            default: return {v[7], v[6:0], 1'b0};
        endcase
    endfunction

    function automatic logic [7:0] exp_flags(input logic [7:0] r, input logic c);
        return {r[7], r == 8'h00, 3'b000, ~^r, 1'b0, c};
    endfunction

    task automatic run_instr(input logic [31:0] code, input int nb, input logic bad, input logic [4:0] st);
        logic [31:0] q;
        int n;
        for (int i = 0; i < nb; i++) rsu_mem_model_i.mem[16'h0100 + i] = code[31 - 8 * i -: 8];
        wr(`RSU_ADDR_PC, 32'h100);
        rdCnt = 0;
        wrCnt = 0;
        wr(`RSU_ADDR_CTRL, 32'h1);
        n = 0;
        do begin
            rd(`RSU_ADDR_STATUS, q);
            n++;
        end while (!(q[0] === 1'b0 && (q[1] | q[2]) === 1'b1) && n < 40);
        chk({30'h0, q[1:0]}, {30'h0, !bad, 1'b0});
        chk({31'h0, q[2]}, {31'h0, bad});
        if (!bad) begin
            rd(`RSU_ADDR_STATES, q);
            chk({27'h0, q[4:0]}, {27'h0, st});
            chk(32'(rdCnt), 32'(nb + (st != 5'h08)));
        end
        chk(32'(wrCnt), {31'h0, !bad && st != 5'h08});
        wr(`RSU_ADDR_STATUS, 32'h7);
        rd(`RSU_ADDR_STATUS, q);
        chk(q, 32'h0);
    endtask

    task automatic s_reset();
        logic [31:0] q;
        logic e;
        for (int a = 0; a <= 8'h28; a += 4) begin
            rd(8'(a), q);
            chk(q, 32'h0);
        end
        apb(1'b0, 8'h2C, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask

    task automatic s_regs();
        logic [7:0] vals [0:7] = '{8'h01, 8'h80, 8'hB1, 8'h31, 8'h4C, 8'hDD, 8'h00, 8'h96};
        logic [7:0] base [0:2] = '{8'h08, 8'h18, 8'h20};
        logic [7:0] rv [0:7];
        logic [8:0] e;
        logic [31:0] q;
        for (int k = 0; k < 3; k++) begin
            for (int r = 0; r < 8; r++) begin
                if (r != 6) begin
                    for (int i = 0; i < 8; i++) rv[i] = (i == r) ? vals[r] : ~vals[r];
                    wr(`RSU_ADDR_BC, {16'h0, rv[0], rv[1]});
                    wr(`RSU_ADDR_DE, {16'h0, rv[2], rv[3]});
                    wr(`RSU_ADDR_PTR, {16'h0, rv[4], rv[5]});
                    wr(`RSU_ADDR_A, {24'h0, rv[7]});
                    wr(`RSU_ADDR_FLAGS, {31'h0, r[0]});
                    run_instr({8'hCB, base[k] | r[7:0], 16'h0}, 2, 1'b0, 5'h08);
                    e = ref_op(k[1:0], vals[r], r[0]);
                    rd((r == 7) ? 8'h1C : 8'h10 + 8'(4 * (r / 2)), q);
                    chk({24'h0, r[0] ? q[7:0] : q[15:8]}, {24'h0, e[7:0]});
                    rd(`RSU_ADDR_FLAGS, q);
                    chk(q, {24'h0, exp_flags(e[7:0], e[8])});
                end
            end
        end
    endtask

    task automatic s_mem();
        logic [31:0] codes [0:3] = '{32'hCB1E0000, 32'hDDCB030E, 32'hFDCBFE26, 32'hDDCB7F1E};
        logic [15:0] addrs [0:3] = '{16'h4343, 16'h1003, 16'h2003, 16'h107F};
        logic [7:0] vals [0:3] = '{8'hDD, 8'hB8, 8'hB1, 8'h01};
        logic [1:0] kinds [0:3] = '{2'h1, 2'h0, 2'h2, 2'h1};
        logic [8:0] e;
        logic [31:0] q;
        wr(`RSU_ADDR_PTR, 32'h4343);
        wr(`RSU_ADDR_IDXX, 32'h1000);
        wr(`RSU_ADDR_IDXY, 32'h2005);
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            wr(`RSU_ADDR_FLAGS, {31'h0, k[1]});
            rsu_mem_model_i.mem[addrs[k]] = vals[k];
            run_instr(codes[k], (k == 0) ? 2 : 4, 1'b0, (k == 0) ? 5'h0F : 5'h17);
            e = ref_op(kinds[k], vals[k], k[1]);
            chk({24'h0, rsu_mem_model_i.mem[addrs[k]]}, {24'h0, e[7:0]});
            rd(`RSU_ADDR_FLAGS, q);
            chk(q, {24'h0, exp_flags(e[7:0], e[8])});
        end
    endtask

    task automatic s_bad();
        logic [31:0] codes [0:3] = '{32'h12000000, 32'hCB300000, 32'hDD080000, 32'hFDCB0008};
        logic [31:0] q;
        for (int k = 0; k < 4; k++) begin
            wr(`RSU_ADDR_A, 32'h5A);
            wr(`RSU_ADDR_FLAGS, 32'h1);
            run_instr(codes[k], 4, 1'b1, 5'h00);
            rd(`RSU_ADDR_A, q);
            chk(q, 32'h5A);
            rd(`RSU_ADDR_FLAGS, q);
            chk(q, 32'h1);
        end
    endtask

    initial begin
        #200000;
        numErrors++;
        wrapUp();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        s_reset();
        s_regs();
        s_mem();
        s_bad();
        wrapUp();
    end
endmodule
